// >>> rtl/pchb_consts.svh
`ifndef PCHB_CONSTS_SVH
`define PCHB_CONSTS_SVH
// ==========================================================
// Configuration offsets (byte addresses)
`define PCHB_A_REV 8'h08
`define PCHB_A_MEM 8'h10
`define PCHB_A_IO 8'h14
`define PCHB_A_FLASH 8'h18
`define PCHB_A_SUBSYS 8'h2c
`define PCHB_A_ROM 8'h30
`define PCHB_A_CAP 8'h34
`define PCHB_A_INT 8'h3c
`define PCHB_A_PM 8'hdc
// ==========================================================
// Window masks and fixed low bits
`define PCHB_MEM_MASK 32'hfffff000
`define PCHB_MEM_LOW 32'h00000008
`define PCHB_IO_MASK 32'hffffffc0
`define PCHB_IO_LOW 32'h00000001
`define PCHB_FLASH_MASK 32'hfffe0000
`define PCHB_ROM_MASK 32'hfff00000
`define PCHB_BAR_RESET 32'h00000000
// ==========================================================
// Fixed header fields
`define PCHB_CLASS 24'h020000
`define PCHB_CAP_PTR 8'hdc
`define PCHB_CAP_ID 8'h01
`define PCHB_CAP_NEXT 8'h00
`define PCHB_INT_PIN 8'h01
`define PCHB_MIN_GNT 8'h08
`define PCHB_MAX_LAT 8'h18
`define PCHB_IRQ_LINE_RESET 8'h00
`define PCHB_WAKE_AUX 5'h1f
`define PCHB_WAKE_NOAUX 5'h0f
`define PCHB_PM_LOW 9'h021
`define PCHB_PM_AUX 16'hfe21
`define PCHB_PM_NOAUX 16'h7e21
// ==========================================================
// EEPROM load
`define PCHB_EE_W_CTRL 6'h0a
`define PCHB_EE_W_PROD 6'h0b
`define PCHB_EE_W_MAKER 6'h0c
`define PCHB_EE_SIG 2'h1
`define PCHB_EE_REVSEL 13
`define PCHB_EE_BOOTDIS 11
`define PCHB_ID_RESET 16'h0000
`define PCHB_EE_OPCODE 3'h6
`define PCHB_EE_BITS 5'h19
`define PCHB_CLK_NS 10
`define PCHB_EE_HALF_NS 1000
`define PCHB_EE_HALF_CYC \
  ((`PCHB_EE_HALF_NS + `PCHB_CLK_NS - 1) / `PCHB_CLK_NS)
`endif

// >>> rtl/pchb_pkg.sv
package pchb_pkg;
  // ========================================================
  // Configuration access carriers
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pchb_cfg_req_type;
  typedef struct packed {
    logic done;
    logic retry;
    logic [31:0] rdata;
  } pchb_cfg_ans_type;
  // ========================================================
  // State machines
  typedef enum {LD_ISSUE, LD_WAIT, LD_READY} pchb_ld_type;
  typedef enum {EE_IDLE, EE_RUN, EE_DONE} pchb_ee_type;
endpackage

// >>> rtl/pchb_eeprom_rd.sv
`timescale 1ns/1ns
`include "pchb_consts.svh"
module pchb_eeprom_rd
  import pchb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Word request
  input wire logic start,
  input wire logic [5:0] addr,
  output logic done_r,
  output logic [15:0] data_r,
  // EEPROM pins
  output logic ee_sk_r,
  output logic ee_cs_r,
  output logic ee_di_r,
  input wire logic ee_do
);
  pchb_ee_type st_r, st_nxt;
  logic [7:0] div_r, div_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [24:0] sh_r, sh_nxt;
  logic sk_nxt, cs_nxt, di_nxt, done_nxt;
  logic [15:0] data_nxt;
  logic do_meta_r, do_sync_r;

  // ========================================================
  // Bit engine
  // One shift register carries command out and data in:
  // each rising edge shifts in, the next falling edge
  // presents the following command bit.
  always_comb
  begin
    st_nxt = st_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    sk_nxt = ee_sk_r;
    cs_nxt = ee_cs_r;
    di_nxt = ee_di_r;
    done_nxt = 1'b0;
    data_nxt = data_r;
    case (st_r)
      EE_IDLE:
        if (start)
        begin
          sh_nxt = {`PCHB_EE_OPCODE, addr, 16'h0000};
          di_nxt = 1'b1;
          cs_nxt = 1'b1;
          sk_nxt = 1'b0;
          div_nxt = 8'h00;
          bit_nxt = 5'h00;
          st_nxt = EE_RUN;
        end
      EE_RUN:
        if (div_r == 8'(`PCHB_EE_HALF_CYC - 1))
        begin
          div_nxt = 8'h00;
          if (!ee_sk_r)
          begin
            sk_nxt = 1'b1;
            sh_nxt = {sh_r[23:0], do_sync_r};
            bit_nxt = bit_r + 5'h01;
          end
          else
          begin
            sk_nxt = 1'b0;
            di_nxt = sh_r[24];
            if (bit_r == `PCHB_EE_BITS)
            begin
              cs_nxt = 1'b0;
              di_nxt = 1'b0;
              st_nxt = EE_DONE;
            end
          end
        end
        else
          div_nxt = div_r + 8'h01;
      EE_DONE:
      begin
        data_nxt = sh_r[15:0];
        done_nxt = 1'b1;
        st_nxt = EE_IDLE;
      end
      default:
        st_nxt = EE_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= EE_IDLE;
      div_r <= 8'h00;
      bit_r <= 5'h00;
      sh_r <= 25'h0000000;
      ee_sk_r <= 1'b0;
      ee_cs_r <= 1'b0;
      ee_di_r <= 1'b0;
      done_r <= 1'b0;
      data_r <= 16'h0000;
      do_meta_r <= 1'b0;
      do_sync_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ee_sk_r <= sk_nxt;
      ee_cs_r <= cs_nxt;
      ee_di_r <= di_nxt;
      done_r <= done_nxt;
      data_r <= data_nxt;
      do_meta_r <= ee_do;
      do_sync_r <= do_meta_r;
    end
  end
endmodule

// >>> rtl/pchb_config_bank.sv
`timescale 1ns/1ns
`include "pchb_consts.svh"
module pchb_config_bank
  import pchb_pkg::*;
#(
  // Arbitrary value
  parameter logic [7:0] REV_ID = 8'h05
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration access
  input wire logic cfg_valid,
  input wire pchb_cfg_req_type cfg_req,
  output pchb_cfg_ans_type cfg_ans_r,
  // Board supply strap
  input wire logic aux_power,
  // Serial EEPROM
  output logic ee_sk_r,
  output logic ee_cs_r,
  output logic ee_di_r,
  input wire logic ee_do
);
  pchb_ld_type ld_r, ld_nxt;
  logic [1:0] word_r, word_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] prod_r, prod_nxt;
  logic [15:0] maker_r, maker_nxt;
  logic ee_start_r, ee_start_nxt;
  logic [5:0] ee_addr_r, ee_addr_nxt;
  logic ee_done;
  logic [15:0] ee_data;
  logic aux_meta_r, aux_sync_r;
  logic [31:0] mem_r, mem_nxt, io_r, io_nxt;
  logic [31:0] fl_r, fl_nxt, rom_r, rom_nxt;
  logic [7:0] irq_line_r, irq_line_nxt;
  pchb_cfg_ans_type ans_nxt;
  logic ready, present, boot_dis;
  logic [7:0] rev;
  logic [15:0] board_product, board_maker, power_features;

  // ========================================================
  // Helpers
  function automatic logic [31:0] lane_wr(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be,
    input logic [31:0] mask
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return ((wd & m) | (old & ~m)) & mask;
  endfunction

  function automatic logic is_reg(
    input logic [7:0] addr,
    input logic [7:0] a
  );
    return addr[7:2] == a[7:2];
  endfunction

  // ========================================================
  // EEPROM word reader
  pchb_eeprom_rd u_ee (
    .clock(clock),
    .rst_n(rst_n),
    .start(ee_start_r),
    .addr(ee_addr_r),
    .done_r(ee_done),
    .data_r(ee_data),
    .ee_sk_r(ee_sk_r),
    .ee_cs_r(ee_cs_r),
    .ee_di_r(ee_di_r),
    .ee_do(ee_do)
  );

  // ========================================================
  // Automatic load after reset
  always_comb
  begin
    ld_nxt = ld_r;
    word_nxt = word_r;
    ctrl_nxt = ctrl_r;
    prod_nxt = prod_r;
    maker_nxt = maker_r;
    ee_start_nxt = 1'b0;
    ee_addr_nxt = ee_addr_r;
    case (ld_r)
      LD_ISSUE:
      begin
        ee_start_nxt = 1'b1;
        ee_addr_nxt = `PCHB_EE_W_CTRL + 6'(word_r);
        ld_nxt = LD_WAIT;
      end
      LD_WAIT:
        if (ee_done)
        begin
          case (word_r)
            2'h0: ctrl_nxt = ee_data;
            2'h1: prod_nxt = ee_data;
            default: maker_nxt = ee_data;
          endcase
          if (word_r == 2'h2)
            ld_nxt = LD_READY;
          else
          begin
            word_nxt = word_r + 2'h1;
            ld_nxt = LD_ISSUE;
          end
        end
      LD_READY:
        ld_nxt = LD_READY;
      default:
        ld_nxt = LD_ISSUE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ld_r <= LD_ISSUE;
      word_r <= 2'h0;
      ctrl_r <= 16'h0000;
      prod_r <= `PCHB_ID_RESET;
      maker_r <= `PCHB_ID_RESET;
      ee_start_r <= 1'b0;
      ee_addr_r <= 6'h00;
    end
    else
    begin
      ld_r <= ld_nxt;
      word_r <= word_nxt;
      ctrl_r <= ctrl_nxt;
      prod_r <= prod_nxt;
      maker_r <= maker_nxt;
      ee_start_r <= ee_start_nxt;
      ee_addr_r <= ee_addr_nxt;
    end
  end

  // ========================================================
  // Loaded identity and fixed fields
  assign ready = (ld_r == LD_READY);
  assign present = ready && (ctrl_r[15:14] == `PCHB_EE_SIG);
  assign boot_dis = present && ctrl_r[`PCHB_EE_BOOTDIS];
  assign board_product = present ? prod_r : `PCHB_ID_RESET;
  assign board_maker = present ? maker_r : `PCHB_ID_RESET;
  assign rev = (present && ctrl_r[`PCHB_EE_REVSEL]) ?
    {REV_ID[7:3], ctrl_r[10:8]} : REV_ID;
  // The strap is driven by board power, not by this clock.
  // Without aux the field value PCHB_WAKE_NOAUX is used, so the wake field is 01111b.
  assign power_features = {
    aux_sync_r ? `PCHB_WAKE_AUX : `PCHB_WAKE_NOAUX,
    1'b1,
    1'b1,
    `PCHB_PM_LOW
  };

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aux_meta_r <= 1'b0;
      aux_sync_r <= 1'b0;
    end
    else
    begin
      aux_meta_r <= aux_power;
      aux_sync_r <= aux_meta_r;
    end
  end

  // ========================================================
  // Configuration cycles
  always_comb
  begin
    mem_nxt = mem_r;
    io_nxt = io_r;
    fl_nxt = fl_r;
    rom_nxt = rom_r;
    irq_line_nxt = irq_line_r;
    ans_nxt = '0;
    if (cfg_valid && !ready)
      ans_nxt.retry = 1'b1;
    else if (cfg_valid)
    begin
      ans_nxt.done = 1'b1;
      if (cfg_req.wr)
      begin
        if (is_reg(cfg_req.addr, `PCHB_A_MEM))
          mem_nxt = lane_wr(mem_r, cfg_req.wdata, cfg_req.be,
            `PCHB_MEM_MASK);
        if (is_reg(cfg_req.addr, `PCHB_A_IO))
          io_nxt = lane_wr(io_r, cfg_req.wdata, cfg_req.be,
            `PCHB_IO_MASK);
        if (is_reg(cfg_req.addr, `PCHB_A_FLASH))
          fl_nxt = lane_wr(fl_r, cfg_req.wdata, cfg_req.be,
            `PCHB_FLASH_MASK);
        if (is_reg(cfg_req.addr, `PCHB_A_ROM))
          rom_nxt = lane_wr(rom_r, cfg_req.wdata, cfg_req.be,
            `PCHB_ROM_MASK);
        if (is_reg(cfg_req.addr, `PCHB_A_INT) && cfg_req.be[0])
          irq_line_nxt = cfg_req.wdata[7:0];
      end
      else
        case ({cfg_req.addr[7:2], 2'b00})
          `PCHB_A_REV:
            ans_nxt.rdata = {`PCHB_CLASS, rev};
          `PCHB_A_MEM:
            ans_nxt.rdata = mem_r | `PCHB_MEM_LOW;
          `PCHB_A_IO:
            ans_nxt.rdata = io_r | `PCHB_IO_LOW;
          `PCHB_A_FLASH:
            ans_nxt.rdata = fl_r;
          `PCHB_A_SUBSYS:
            ans_nxt.rdata = {board_product, board_maker};
          `PCHB_A_ROM:
            ans_nxt.rdata = boot_dis ? 32'h0 : rom_r;
          `PCHB_A_CAP:
            ans_nxt.rdata = {24'h0, `PCHB_CAP_PTR};
          `PCHB_A_INT:
            ans_nxt.rdata = {`PCHB_MAX_LAT, `PCHB_MIN_GNT,
              `PCHB_INT_PIN, irq_line_r};
          `PCHB_A_PM:
            ans_nxt.rdata = {power_features,
              `PCHB_CAP_NEXT, `PCHB_CAP_ID};
          default:
            ans_nxt.rdata = 32'h0;
        endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_r <= `PCHB_BAR_RESET;
      io_r <= `PCHB_BAR_RESET;
      fl_r <= `PCHB_BAR_RESET;
      rom_r <= `PCHB_BAR_RESET;
      irq_line_r <= `PCHB_IRQ_LINE_RESET;
      cfg_ans_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
      io_r <= io_nxt;
      fl_r <= fl_nxt;
      rom_r <= rom_nxt;
      irq_line_r <= irq_line_nxt;
      cfg_ans_r <= ans_nxt;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [7:0] a);
    cfg_valid && ready && !cfg_req.wr && is_reg(cfg_req.addr, a);
  endsequence

  sequence s_wr_ones(logic [7:0] a);
    cfg_valid && ready && cfg_req.wr && is_reg(cfg_req.addr, a)
      && cfg_req.be == 4'hf && cfg_req.wdata == 32'hffffffff;
  endsequence

  a_retry_load: assert property (
    cfg_valid && !ready |=> cfg_ans_r.retry && !cfg_ans_r.done)
    else $error("access during load not retried");

  a_load_words: assert property (
    ee_start_r |-> ##[1:2] ee_addr_r >= `PCHB_EE_W_CTRL
      && ee_addr_r <= `PCHB_EE_W_MAKER)
    else $error("load reads wrong word");

  a_mem_sizing: assert property (
    s_wr_ones(`PCHB_A_MEM) ##1 s_rd(`PCHB_A_MEM)
      |=> cfg_ans_r.rdata == 32'hfffff008)
    else $error("memory window sizing wrong");

  a_io_sizing: assert property (
    s_wr_ones(`PCHB_A_IO) ##1 s_rd(`PCHB_A_IO)
      |=> cfg_ans_r.rdata == 32'hffffffc1)
    else $error("io window sizing wrong");

  a_flash_size: assert property (
    s_wr_ones(`PCHB_A_FLASH) ##1 s_rd(`PCHB_A_FLASH)
      |=> cfg_ans_r.rdata == 32'hfffe0000)
    else $error("flash window sizing wrong");

  a_rom_disable: assert property (
    s_rd(`PCHB_A_ROM) ##0 boot_dis |=> cfg_ans_r.rdata == 32'h0)
    else $error("disabled boot rom base not zero");

  a_rom_size: assert property (
    s_rd(`PCHB_A_ROM) |=> cfg_ans_r.rdata[19:0] == 20'h0)
    else $error("boot rom window not 1 megabyte");

  a_ids_default: assert property (
    s_rd(`PCHB_A_SUBSYS) ##0 !present |=> cfg_ans_r.rdata == 32'h0)
    else $error("ids not default without eeprom");

  a_rev_override: assert property (
    s_rd(`PCHB_A_REV) ##0 present ##0 ctrl_r[`PCHB_EE_REVSEL]
      |=> cfg_ans_r.rdata[2:0] == $past(ctrl_r[10:8]))
    else $error("revision override missing");

  a_fixed_int: assert property (
    s_rd(`PCHB_A_INT) |=> cfg_ans_r.rdata[31:8] == 24'h180801)
    else $error("interrupt pin or bus hints wrong");

  a_pm_word: assert property (
    s_rd(`PCHB_A_PM) |=> cfg_ans_r.rdata == ($past(aux_sync_r) ?
      32'hfe210001 : 32'h7e210001))
    else $error("power capability word wrong");
endmodule

// >>> testbench/pchb_eeprom_model.sv
`timescale 1ns/1ns
// ====================
// Serial EEPROM stand-in, one word read per chip-select frame
module pchb_eeprom_model
(
  // Serial pins
  input wire logic sk,
  input wire logic cs,
  input wire logic di,
  output logic dout,
  // Stored words and what the device asked for
  input wire logic [15:0] w_ctrl,
  input wire logic [15:0] w_prod,
  input wire logic [15:0] w_maker,
  output logic [17:0] addr_seq,
  output logic [2:0] op_seen
);
  int n = 0;
  logic [8:0] cmd = 9'h000;
  logic [15:0] word = 16'h0000;
  initial
  begin
    dout = 1'b0;
    addr_seq = 18'h00000;
    op_seen = 3'h0;
  end
  always @(posedge cs)
    n = 0;
  always @(posedge sk)
    if (cs)
    begin
      if (n < 9)
        cmd = {cmd[7:0], di};
      n = n + 1;
      if (n == 9)
      begin
        op_seen = cmd[8:6];
        addr_seq = {addr_seq[11:0], cmd[5:0]};
        word = cmd[5:0] == 6'h0a ? w_ctrl : cmd[5:0] == 6'h0b ? w_prod :
          cmd[5:0] == 6'h0c ? w_maker : 16'hffff;
      end
    end
  // Outside the data phase the line floats: toggle so nothing passes by luck
  always @(negedge sk or negedge cs)
    if (cs && n >= 9 && n < 25)
      dout = word[24 - n];
    else
      dout = ~dout;
endmodule

// >>> testbench/pchb_config_bank_tb.sv
`timescale 1ns/1ns
`include "pchb_consts.svh"
`define CHK(nm, e, g) \
  begin n_compared++; if ((g) !== (e)) begin \
  $display("wrong value %s expected %h seen %h", nm, e, g); \
  n_errors++; end end
module pchb_config_bank_tb
  import pchb_pkg::*;
;
  typedef struct packed {logic retry; logic [31:0] rdata;} pchb_note_type;
  // Arbitrary revision value
  localparam logic [7:0] REV = 8'h5a;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_valid = 1'b0;
  logic aux_power = 1'b1;
  pchb_cfg_req_type cfg_req = '0;
  pchb_cfg_ans_type cfg_ans_r;
  logic ee_sk_r, ee_cs_r, ee_di_r, ee_do;
  logic [15:0] w_ctrl = 16'h0000;
  logic [15:0] w_prod = 16'h0000;
  logic [15:0] w_maker = 16'h0000;
  logic [17:0] addr_seq;
  logic [2:0] op_seen;
  logic [2:0] r3;
  logic [7:0] line;
  logic [31:0] wd;
  logic [1:0] sig;
  pchb_note_type notes[$];
  pchb_note_type nt;
  logic [33:0] ans_seen;
  int n_errors = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  pchb_config_bank #(.REV_ID(REV)) DUT (.clock(clock), .rst_n(rst_n),
    .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_ans_r(cfg_ans_r),
    .aux_power(aux_power), .ee_sk_r(ee_sk_r), .ee_cs_r(ee_cs_r),
    .ee_di_r(ee_di_r), .ee_do(ee_do));
  pchb_eeprom_model EE (.sk(ee_sk_r), .cs(ee_cs_r), .di(ee_di_r),
    .dout(ee_do), .w_ctrl(w_ctrl), .w_prod(w_prod), .w_maker(w_maker),
    .addr_seq(addr_seq), .op_seen(op_seen));
  // ====================
  // Bus driver; valid is left high so accesses can go back to back
  task automatic acc(input logic wr, input logic [7:0] a,
    input logic [3:0] be, input logic [31:0] d, input logic rt,
    input logic [31:0] e);
    notes.push_back({rt, e});
    @(posedge clock);
    cfg_valid <= 1'b1;
    cfg_req <= {wr, a, be, d};
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 4'hf, 32'h0, 1'b0, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    acc(1'b1, a, be, d, 1'b0, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clock);
      cfg_valid <= 1'b0;
    end
  endtask
  task automatic done_test(input string name);
    idle(3);
    `CHK("pending answers", 0, notes.size())
    $display("test %s done", name);
  endtask
  // Reset, then follow the automatic word load, poking it meanwhile
  task automatic load(input logic [15:0] c, input logic [15:0] p,
    input logic [15:0] m);
    @(posedge clock);
    rst_n <= 1'b0;
    w_ctrl <= c;
    w_prod <= p;
    w_maker <= m;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    acc(1'b0, `PCHB_A_CAP, 4'hf, 32'h0, 1'b1, 32'h0);
    idle(1);
    @(negedge ee_cs_r);
    acc(1'b1, `PCHB_A_INT, 4'h1, 32'hff, 1'b1, 32'h0);
    idle(1);
    repeat (2) @(negedge ee_cs_r);
    idle(4);
    `CHK("word order", {6'h0a, 6'h0b, 6'h0c}, addr_seq)
    `CHK("read opcode", 3'b110, op_seen)
  endtask
  // ====================
  // Answer watcher
  always @(negedge clock)
    if (cfg_ans_r.done === 1'b1 || cfg_ans_r.retry === 1'b1)
    begin
      if (notes.size() == 0)
        nt = {1'b0, 32'hdeadbeef};
      else
        nt = notes.pop_front();
      ans_seen = {cfg_ans_r.retry, cfg_ans_r.done, cfg_ans_r.rdata};
      `CHK("answer", {nt.retry, ~nt.retry, nt.rdata}, ans_seen)
    end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (95000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(9449));
    r3 = 3'($urandom);
    load({5'b01100, r3, 8'($urandom)}, 16'h1c3e, 16'h7a51);
    rd(`PCHB_A_REV, {24'h020000, REV[7:3], r3});
    rd(`PCHB_A_SUBSYS, 32'h1c3e7a51);
    rd(`PCHB_A_INT, 32'h18080100);
    wr(`PCHB_A_MEM, 4'hf, 32'hffffffff);
    rd(`PCHB_A_MEM, 32'hfffff008);
    wr(`PCHB_A_IO, 4'hf, 32'hffffffff);
    rd(`PCHB_A_IO, 32'hffffffc1);
    wr(`PCHB_A_FLASH, 4'hf, 32'hffffffff);
    rd(`PCHB_A_FLASH, 32'hfffe0000);
    wr(`PCHB_A_ROM, 4'hf, 32'hffffffff);
    rd(`PCHB_A_ROM, 32'hfff00000);
    wd = $urandom;
    wr(`PCHB_A_MEM, 4'hf, wd);
    rd(`PCHB_A_MEM, (wd & 32'hfffff000) | 32'h8);
    wr(`PCHB_A_IO, 4'b0010, ~wd);
    rd(`PCHB_A_IO, {16'hffff, ~wd[15:8], 8'hc1});
    line = 8'($urandom);
    wr(`PCHB_A_INT, 4'hf, {wd[31:8], line});
    rd(`PCHB_A_INT, {24'h180801, line});
    wr(`PCHB_A_CAP, 4'hf, 32'hffffffff);
    rd(`PCHB_A_CAP, 32'h000000dc);
    rd(8'hf0, 32'h0);
    rd(`PCHB_A_PM, 32'hfe210001);
    idle(1);
    aux_power <= 1'b0;
    idle(3);
    rd(`PCHB_A_PM, 32'h7e210001);
    done_test("windows and fixed fields");
    load({5'b01001, 3'b111, 8'($urandom)}, 16'hbeef, 16'h0f0f);
    rd(`PCHB_A_REV, {24'h020000, REV});
    rd(`PCHB_A_SUBSYS, 32'hbeef0f0f);
    wr(`PCHB_A_ROM, 4'hf, 32'hffffffff);
    rd(`PCHB_A_ROM, 32'h0);
    done_test("boot disable");
    // Every signature other than 01 means no EEPROM
    for (int i = 0; i < 3; i++)
    begin
      sig = i == 0 ? 2'b11 : i == 1 ? 2'b10 : 2'b00;
      load({sig, 3'b101, 3'b111, 8'($urandom)}, 16'h1234, 16'h5678);
      rd(`PCHB_A_SUBSYS, 32'h0);
      rd(`PCHB_A_REV, {24'h020000, REV});
      wr(`PCHB_A_ROM, 4'hf, 32'hffffffff);
      rd(`PCHB_A_ROM, 32'hfff00000);
      done_test("absent eeprom");
    end
    end_of_test();
  end
endmodule
